//--- rtl/pllc_pkg.sv
// Purpose: Shared constants for the PLL configuration register block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: Status register layout is local to this block
package pllc_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam int ADDR_W = 12;

    // Control register fields
    localparam int EN_BIT = 15;
    localparam int REF_LSB = 12;
    localparam int REF_MSB = 13;
    localparam int FRONT_BIT = 8;
    localparam int POST_LSB = 5;
    localparam int POST_MSB = 7;
    localparam int MULT_LSB = 0;
    localparam int MULT_MSB = 4;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_B1FF;

    // Control reset values
    localparam logic RST_EN = 1'b0;
    localparam logic [1:0] RST_REF = 2'h0;
    localparam logic RST_FRONT = 1'b0;
    localparam logic [2:0] RST_POST = 3'h3;
    localparam logic [4:0] RST_MULT = 5'h03;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0063;

    // Reference select codes
    localparam logic [1:0] REF_INTERNAL_RC = 2'h0;
    localparam logic [1:0] REF_EXTERNAL_XTAL = 2'h1;

    // Status register fields
    localparam int LOCK_BIT = 6;
    localparam int CHOICE_LSB = 8;
    localparam int CURRENT_LSB = 12;

    // System clock code that names the PLL output
    localparam logic [2:0] SYSCLK_PLL = 3'h4;
endpackage : pllc_pkg

//--- rtl/pllc_ratio.sv
// Purpose: Decodes divider fields into numeric division and multiply ratios
// Assumes: Reserved codes pass through unchanged, no clamping
// Notes: Fvco = Fin / front * mult, Fout = Fvco / post
`timescale 1ns/1ps
module pllc_ratio (
    pllc_ratio_if.calc r
);
    always_comb begin
        r.front_ratio = r.front_sel ? 2'h2 : 2'h1;
        r.post_ratio = {r.post_sel, 1'b0};
        r.mult_factor = r.mult_sel;
    end
endmodule : pllc_ratio

//--- rtl/pllc_ratio_if.sv
// Purpose: Carries divider fields to the ratio decoder and ratios back
// Assumes: Single clock domain, purely combinational path
// Notes: None
`timescale 1ns/1ps
interface pllc_ratio_if;
    logic front_sel;
    logic [2:0] post_sel;
    logic [4:0] mult_sel;
    logic [1:0] front_ratio;
    logic [3:0] post_ratio;
    logic [4:0] mult_factor;

    modport src (
        output front_sel,
        output post_sel,
        output mult_sel,
        input front_ratio,
        input post_ratio,
        input mult_factor
    );
    modport calc (
        input front_sel,
        input post_sel,
        input mult_sel,
        output front_ratio,
        output post_ratio,
        output mult_factor
    );
endinterface : pllc_ratio_if

//--- rtl/pllc_top.sv
// Purpose: PLL control register with disable protection, AHB-Lite slave
// Assumes: Clock switch logic runs on hclk; lock input is asynchronous
// Notes: Zero wait state slave, always OKAY
// Functional notes
// - A write's clearing of the enable bit is ignored, other fields still update, while the PLL is, or is chosen to be, sysclk.
// - Bit 15 enables the PLL when 1 and disables it when 0, and resets to 0.
// - Bits 13:12 pick the reference, 00 internal RC and 01 external crystal, reset 00.
// - Bit 8 sets the front ratio to 1 when 0 and 2 when 1, reset 0.
// - Bits 7:5 set the post ratio to twice the code, reset 011.
// - Bits 4:0 hold the feedback factor directly, reset 3.
// - A read-only flag shows 0 while the loop is unlocked and 1 once locked.
// - Clock code 100 in choice or current status names the PLL as system clock.
`timescale 1ns/1ps
module pllc_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // System clock switch state
    input wire logic [2:0] system_clock_choice,
    input wire logic [2:0] system_clock_current,
    // Analog PLL
    input wire logic pll_lock_in,
    output logic pll_enable_bit,
    output logic [1:0] pll_reference_select,
    output logic front_divide_select,
    output logic [2:0] post_divide_select,
    output logic [4:0] feedback_multiply_select,
    // Decoded ratios and status
    output logic [1:0] front_ratio,
    output logic [3:0] post_ratio,
    output logic [4:0] feedback_factor,
    output logic pll_lock_flag
);
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic wr_pend_reg;
    logic [pllc_pkg::ADDR_W-1:0] wr_addr_reg;
    logic lock_s1_reg;
    logic lock_s2_reg;
    logic pll_protected;
    logic addr_phase;
    logic ctrl_wr;
    logic [31:0] stat_value;
    logic [31:0] read_value;

    pllc_ratio_if rif ();

    pllc_ratio u_ratio (
        .r(rif)
    );

    assign addr_phase = hsel && htrans[1] && hready;
    assign ctrl_wr = wr_pend_reg && (wr_addr_reg == pllc_pkg::ADDR_CTRL);
    assign pll_protected = (system_clock_choice == pllc_pkg::SYSCLK_PLL) ||
                           (system_clock_current == pllc_pkg::SYSCLK_PLL);

    // Write data arrives one cycle after the address; next value is used for
    // the read mux too, so a read right behind a write sees the new value.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next = hwdata & pllc_pkg::CTRL_WMASK;
            if (pll_protected && ctrl_reg[pllc_pkg::EN_BIT]) begin
                ctrl_next[pllc_pkg::EN_BIT] = 1'b1;
            end
        end
    end

    assign rif.front_sel = ctrl_next[pllc_pkg::FRONT_BIT];
    assign rif.post_sel = ctrl_next[pllc_pkg::POST_MSB:pllc_pkg::POST_LSB];
    assign rif.mult_sel = ctrl_next[pllc_pkg::MULT_MSB:pllc_pkg::MULT_LSB];

    always_comb begin
        stat_value = 32'h0000_0000;
        stat_value[pllc_pkg::LOCK_BIT] = lock_s2_reg;
        stat_value[pllc_pkg::CHOICE_LSB +: 3] = system_clock_choice;
        stat_value[pllc_pkg::CURRENT_LSB +: 3] = system_clock_current;
    end

    always_comb begin
        case (haddr[pllc_pkg::ADDR_W-1:0])
            pllc_pkg::ADDR_CTRL: read_value = ctrl_next;
            pllc_pkg::ADDR_STAT: read_value = stat_value;
            default: read_value = 32'h0000_0000;
        endcase
    end

    // Bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr[pllc_pkg::ADDR_W-1:0];
        end
    end

    // Bus response; hsize is not checked, only word access is supported
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_phase && !hwrite) begin
                hrdata <= read_value;
            end
        end
    end

    // Control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= pllc_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Field outputs and ratios registered from the same next value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_enable_bit <= pllc_pkg::RST_EN;
            pll_reference_select <= pllc_pkg::RST_REF;
            front_divide_select <= pllc_pkg::RST_FRONT;
            post_divide_select <= pllc_pkg::RST_POST;
            feedback_multiply_select <= pllc_pkg::RST_MULT;
            front_ratio <= 2'h1;
            post_ratio <= 4'h6;
            feedback_factor <= pllc_pkg::RST_MULT;
        end else begin
            pll_enable_bit <= ctrl_next[pllc_pkg::EN_BIT];
            pll_reference_select <= ctrl_next[pllc_pkg::REF_MSB:pllc_pkg::REF_LSB];
            front_divide_select <= rif.front_sel;
            post_divide_select <= rif.post_sel;
            feedback_multiply_select <= rif.mult_sel;
            front_ratio <= rif.front_ratio;
            post_ratio <= rif.post_ratio;
            feedback_factor <= rif.mult_factor;
        end
    end

    // Lock input comes from the analog loop, so it is synchronised first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
            pll_lock_flag <= 1'b0;
        end else begin
            lock_s1_reg <= pll_lock_in;
            lock_s2_reg <= lock_s1_reg;
            pll_lock_flag <= lock_s2_reg;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    enable_protect_a: assert property (
        (ctrl_wr && pll_protected && pll_enable_bit) |=> pll_enable_bit)
        else $error("Protected PLL enable was cleared");
    enable_write_a: assert property (
        (ctrl_wr && !pll_protected) |=> pll_enable_bit == $past(hwdata[15]))
        else $error("PLL enable did not follow write");
    ref_write_a: assert property (
        ctrl_wr |=> pll_reference_select == $past(hwdata[13:12]))
        else $error("Reference select did not follow write");
    front_ratio_a: assert property (
        front_ratio == (front_divide_select ? 2'h2 : 2'h1))
        else $error("Front ratio mismatch");
    post_ratio_a: assert property (
        ctrl_wr |=> post_ratio == {$past(hwdata[7:5]), 1'b0})
        else $error("Post ratio mismatch");
    mult_write_a: assert property (
        ctrl_wr |=> feedback_factor == $past(hwdata[4:0]))
        else $error("Feedback factor mismatch");
    ratio_consistent_a: assert property (
        post_ratio[0] == 1'b0 && post_ratio[3:1] == post_divide_select &&
        feedback_factor == feedback_multiply_select)
        else $error("Ratios disagree with fields");
    fields_kept_a: assert property (
        (ctrl_wr && pll_protected && pll_enable_bit) |=>
        ctrl_reg[14:0] == ($past(hwdata[14:0]) & 15'h31FF))
        else $error("Fields not updated on blocked disable");
    lock_delay_a: assert property (
        ##3 pll_lock_flag == $past(pll_lock_in, 3))
        else $error("Lock flag delay wrong");

    protected_write_c: cover property (ctrl_wr && pll_protected && pll_enable_bit);
    enable_on_c: cover property (!pll_enable_bit ##1 pll_enable_bit);
    lock_seen_c: cover property (!pll_lock_flag ##1 pll_lock_flag);
    ctrl_read_c: cover property (addr_phase && !hwrite && haddr[11:0] == 12'h004);
endmodule : pllc_top

//--- tb/pllc_top_tb_top.sv
// Purpose: Self-checking bench for the PLL control register block
// Assumes: Zero wait state slave, hready looped back from hreadyout
// Notes: Checks fields, ratios, disable protection, lock sync and status
`timescale 1ns/1ps
module pllc_top_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hready;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pll_lock_in = 1'b0;
    logic [2:0] choice = 3'h0;
    logic [2:0] current = 3'h0;
    logic en, front, lock_flag;
    logic [1:0] ref_sel, front_ratio;
    logic [2:0] post;
    logic [3:0] post_ratio;
    logic [4:0] mult, factor;
    int fail_count = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [31:0] vals [3] = '{32'h0000_11FF, 32'h0000_0090, 32'hFFFF_FFFF};

    always #12.5 hclk = ~hclk;
    // The one slave's answer is the bus ready
    assign hready = hreadyout;

    pllc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .system_clock_choice(choice), .system_clock_current(current),
        .pll_lock_in(pll_lock_in), .pll_enable_bit(en), .pll_reference_select(ref_sel),
        .front_divide_select(front), .post_divide_select(post),
        .feedback_multiply_select(mult), .front_ratio(front_ratio),
        .post_ratio(post_ratio), .feedback_factor(factor), .pll_lock_flag(lock_flag));

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("response", {31'h0, hresp}, 32'h0000_0000);
    endtask : ahb

    // Register value and every derived output must agree with e
    task chk_ctrl(input logic [31:0] e);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("ctrl", rd, e);
        @(negedge hclk);
        chk("ready", {31'h0, hreadyout}, 32'h0000_0001);
        chk("enable", {31'h0, en}, {31'h0, e[15]});
        chk("ref", {30'h0, ref_sel}, {30'h0, e[13:12]});
        chk("front", {30'h0, front_ratio}, 32'h1 << e[8]);
        chk("post", {28'h0, post_ratio}, {28'h0, e[7:5], 1'b0});
        chk("mult", {27'h0, factor}, {27'h0, e[4:0]});
        chk("fields", {23'h0, front, post, mult}, {23'h0, e[8:0]});
        @(posedge hclk);
    endtask : chk_ctrl

    task t_reset;
        chk_ctrl(32'h0000_0063);
        $display("test reset done");
    endtask : t_reset

    task t_fields;
        foreach (vals[i]) begin
            ahb(1'b1, 32'h0000_0004, vals[i]);
            chk_ctrl(vals[i] & pllc_pkg::CTRL_WMASK);
        end
        // 12 MHz internal reference, 288 MHz oscillator, 48 MHz out
        ahb(1'b1, 32'h0000_0004, 32'h0000_0078);
        chk_ctrl(32'h0000_0078);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0000);
        chk_ctrl(32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        chk_ctrl(32'h0000_0000);
        $display("test fields done");
    endtask : t_fields

    task t_protect;
        ahb(1'b1, 32'h0000_0004, 32'h0000_B1FF);
        choice <= 3'h4;
        ahb(1'b1, 32'h0000_0004, 32'h0000_0063);
        chk_ctrl(32'h0000_8063);
        choice <= 3'h3;
        current <= 3'h4;
        ahb(1'b1, 32'h0000_0004, 32'h0000_0090);
        chk_ctrl(32'h0000_8090);
        current <= 3'h3;
        ahb(1'b1, 32'h0000_0004, 32'h0000_0090);
        chk_ctrl(32'h0000_0090);
        $display("test protect done");
    endtask : t_protect

    task t_lock;
        choice <= 3'h4;
        current <= 3'h4;
        pll_lock_in <= 1'b1;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("lock early", {31'h0, lock_flag}, 32'h0000_0000);
        @(negedge hclk);
        chk("lock", {31'h0, lock_flag}, 32'h0000_0001);
        @(posedge hclk);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk("status", rd, 32'h0000_4440);
        pll_lock_in <= 1'b0;
        repeat (4) @(posedge hclk);
        // Status is read only, so a write there must change nothing
        ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk("status unlocked", rd, 32'h0000_4400);
        $display("test lock done");
    endtask : t_lock

    // Reset in mid-run must bring back the reset values over written ones
    task t_midreset;
        ahb(1'b1, 32'h0000_0004, 32'h0000_B1FF);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_ctrl(32'h0000_0063);
        $display("test midreset done");
    endtask : t_midreset

    task results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_fields();
        t_protect();
        t_lock();
        t_midreset();
        results();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        results();
    end
endmodule : pllc_top_tb_top
